// ==== design/utc_pkg.sv ====
// Purpose: Shared constants, types and helpers for the token capture and transceiver control block
// Assumes: 32-bit register port, byte addresses on aligned words
// Notes: Shared offsets, field positions, reset values and masks live here

package utc_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFS_LAST_PACKET_ID = 8'h2c;
	localparam logic [7:0] OFS_LAST_ENDPOINT = 8'h30;
	localparam logic [7:0] OFS_ENDPOINT_MARK_MASK = 8'h34;
	localparam logic [7:0] OFS_OTG_FLAG_MASK = 8'h38;
	localparam logic [7:0] OFS_POWER_SIGNALLING = 8'h3c;
	localparam logic [7:0] OFS_TRANSCEIVER_CONTROL = 8'h40;
	localparam logic [7:0] OFS_LINE_STATUS = 8'h44;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h48;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h4c;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int EP_VALID_BIT = 4;
	localparam int PWR_VALID_BIT = 8;
	localparam int CTRL_PD_OFF_BIT = 18;
	localparam int CTRL_RST_FLAG_BIT = 13;
	localparam int CTRL_RES_FLAG_BIT = 12;
	localparam int CTRL_DLY_LSB = 8;
	localparam int CTRL_HW_SUSP_BIT = 7;
	localparam int CTRL_CFG_LSB = 4;
	localparam int LSTAT_STATE_LSB = 2;
	localparam int IRQ_TOKEN_BIT = 0;
	localparam int IRQ_RESUME_BIT = 1;
	localparam int IRQ_RESET_BIT = 2;
	localparam int IRQ_LINE_BIT = 3;

	// ****************************************
	// Reset values and masks
	// ****************************************
	localparam logic [31:0] CTRL_WMASK = 32'h0004_3ff0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] EP_MASK_RST = 16'h0000;
	localparam logic [31:0] OTG_MASK_RST = 32'h0000_0000;
	localparam logic [8:0] PWR_RST = 9'h000;
	localparam logic [3:0] IRQ_RST = 4'h0;
	localparam logic [3:0] PID_RST = 4'h0;
	localparam logic [7:0] RX_MARK = 8'h10;

	// ****************************************
	// Line states
	// ****************************************
	localparam logic [1:0] LS_SE0 = 2'b00;
	localparam logic [1:0] LS_J = 2'b01;
	localparam logic [1:0] LS_K = 2'b10;
	localparam logic [1:0] LS_RST = 2'b00;

	// ****************************************
	// Suspend controller states
	// ****************************************
	typedef enum logic [1:0] {
		UTC_ACTIVE = 2'b00,
		UTC_SUSPEND = 2'b01,
		UTC_RESUME = 2'b11
	} utc_susp_e;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] utc_pow2(input logic [3:0] n);
		return 16'h0001 << n;
	endfunction

	function automatic logic [3:0] utc_w1c(input logic [3:0] old, input logic [3:0] clr, input logic [3:0] set);
		return (old & ~clr) | set;
	endfunction

endpackage

// ==== design/utc_line_filter.sv ====
// Purpose: Synchronise the transceiver line state and hold back each change for a programmable time
// Assumes: Raw line state is asynchronous to clk
// Notes: A change counts once the second and third sync stages agree

`timescale 1ns/1ps

module utc_line_filter (
	// Clock, enable and reset
	input wire logic clk,
	input wire logic clk_en,
	input wire logic rst_n,
	// Line
	input wire logic [1:0] line_raw,
	input wire logic [3:0] delay_log2,
	output logic [1:0] line_filt,
	output logic changed
);

	logic [1:0] s1_q;
	logic [1:0] s2_q;
	logic [1:0] s3_q;
	logic [1:0] pend_q;
	logic [1:0] pend_d;
	logic [1:0] filt_q;
	logic [1:0] filt_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic chg_q;
	logic chg_d;

	// ****************************************
	// Hold-off counter
	// ****************************************
	always_comb begin
		pend_d = pend_q;
		cnt_d = cnt_q;
		filt_d = filt_q;
		chg_d = 1'b0;
		if (s2_q == s3_q) begin
			if (s3_q == filt_q) begin
				pend_d = filt_q;
				cnt_d = 16'h0000;
			end else if (s3_q != pend_q) begin
				pend_d = s3_q;
				cnt_d = 16'h0001;
			end else if (cnt_q >= utc_pkg::utc_pow2(delay_log2)) begin
				filt_d = pend_q;
				chg_d = 1'b1;
				cnt_d = 16'h0000;
			end else begin
				cnt_d = cnt_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= utc_pkg::LS_RST;
			s2_q <= utc_pkg::LS_RST;
			s3_q <= utc_pkg::LS_RST;
			pend_q <= utc_pkg::LS_RST;
			filt_q <= utc_pkg::LS_RST;
			cnt_q <= 16'h0000;
			chg_q <= 1'b0;
		end else if (clk_en) begin
			s1_q <= line_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			pend_q <= pend_d;
			filt_q <= filt_d;
			cnt_q <= cnt_d;
			chg_q <= chg_d;
		end
	end

	assign line_filt = filt_q;
	assign changed = chg_q;

endmodule

// ==== design/utc_token_capture.sv ====
// Purpose: Capture identifier and endpoint of received packets and feed the receive port
// Assumes: Decoder strobes are one-cycle pulses on clk
// Notes: A token strobe comes with its packet strobe

`timescale 1ns/1ps

module utc_token_capture (
	// Clock, enable and reset
	input wire logic clk,
	input wire logic clk_en,
	input wire logic rst_n,
	// Decoder
	input wire logic pkt_valid,
	input wire logic [3:0] pkt_pid,
	input wire logic tok_valid,
	input wire logic [3:0] tok_ep,
	input wire logic [15:0] ep_mask,
	// Captured values
	output logic [3:0] last_pid,
	output logic [3:0] last_ep,
	output logic ep_valid,
	// Receive port
	output logic rx_valid,
	output logic [7:0] rx_data
);

	logic [3:0] pid_q;
	logic [3:0] pid_d;
	logic [3:0] ep_q;
	logic [3:0] ep_d;
	logic epv_q;
	logic epv_d;
	logic rxv_q;
	logic rxv_d;
	logic [7:0] rxd_q;
	logic [7:0] rxd_d;

	always_comb begin
		pid_d = pkt_valid ? pkt_pid : pid_q;
		ep_d = tok_valid ? tok_ep : ep_q;
		epv_d = tok_valid | (epv_q & ~pkt_valid);
		rxv_d = tok_valid;
		rxd_d = 8'h00;
		if (tok_valid) begin
			rxd_d = {4'h0, tok_ep} | (ep_mask[tok_ep] ? utc_pkg::RX_MARK : 8'h00);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pid_q <= utc_pkg::PID_RST;
			ep_q <= 4'h0;
			epv_q <= 1'b0;
			rxv_q <= 1'b0;
			rxd_q <= 8'h00;
		end else if (clk_en) begin
			pid_q <= pid_d;
			ep_q <= ep_d;
			epv_q <= epv_d;
			rxv_q <= rxv_d;
			rxd_q <= rxd_d;
		end
	end

	assign last_pid = pid_q;
	assign last_ep = ep_q;
	assign ep_valid = epv_q;
	assign rx_valid = rxv_q;
	assign rx_data = rxd_q;

endmodule

// ==== design/utc_top.sv ====
// Purpose: Token capture and transceiver control registers of the USB interface unit
// Assumes: Decoder strobes and suspend request on clk; raw line state asynchronous
// Notes: Register reads answer one cycle after the read strobe
// Function
// - Hold last received packet identifier, reset zero
// - Keep endpoint number of last token
// - Valid flag marks captured endpoint as valid
// - Sixteen-bit endpoint mark mask, clear at reset
// - Marked endpoint goes to receive port ORed
// - Control bit turns off pulldowns, ports 8A/8B
// - SE0 auto-resume sets reset flag, write-zero clears
// - K auto-resume sets resume flag, write-zero clears
// - Line change delayed two-to-the-field clocks
// - Control bit selects hardware or software resume
// - Control field drives three transceiver config pins

`timescale 1ns/1ps

module utc_top (
	// Clock, enable and reset
	input wire logic clk,
	input wire logic clk_en,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Token decoder
	input wire logic pkt_valid,
	input wire logic [3:0] pkt_pid,
	input wire logic tok_valid,
	input wire logic [3:0] tok_ep,
	// Receive port
	output logic rx_valid,
	output logic [7:0] rx_data,
	// Transceiver and line
	input wire logic [1:0] line_state,
	input wire logic suspend_req,
	output logic phy_suspend_b,
	output logic [2:0] transceiver_config_pins,
	output logic pulldown_off_8a,
	output logic pulldown_off_8b,
	output logic [1:0] line_state_filt,
	// Interrupt
	output logic irq
);

	// ****************************************
	// Reset release
	// ****************************************
	logic rst_s1_q;
	logic rst_n_s;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_n_s <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_s <= rst_s1_q;
		end
	end

	// ****************************************
	// Declarations
	// ****************************************
	logic [15:0] ep_mask_q;
	logic [15:0] ep_mask_d;
	logic [31:0] otg_mask_q;
	logic [31:0] otg_mask_d;
	logic [8:0] pwr_q;
	logic [8:0] pwr_d;
	logic [31:0] ctrl_q;
	logic [31:0] ctrl_d;
	logic [3:0] irq_st_q;
	logic [3:0] irq_st_d;
	logic [3:0] irq_mask_q;
	logic [3:0] irq_mask_d;
	logic irq_q;
	logic irq_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	utc_pkg::utc_susp_e state_q;
	utc_pkg::utc_susp_e state_d;
	logic susp_b_q;
	logic susp_b_d;
	logic sreq_q;
	logic set_rst_flag;
	logic set_res_flag;
	logic [3:0] pid_v;
	logic [3:0] ep_v;
	logic ep_ok;
	logic [1:0] ls_filt;
	logic ls_chg;
	logic [3:0] irq_clr;
	logic [3:0] irq_ev;

	// ****************************************
	// Submodules
	// ****************************************
	utc_token_capture u_cap (
		.clk(clk),
		.clk_en(clk_en),
		.rst_n(rst_n_s),
		.pkt_valid(pkt_valid),
		.pkt_pid(pkt_pid),
		.tok_valid(tok_valid),
		.tok_ep(tok_ep),
		.ep_mask(ep_mask_q),
		.last_pid(pid_v),
		.last_ep(ep_v),
		.ep_valid(ep_ok),
		.rx_valid(rx_valid),
		.rx_data(rx_data)
	);

	utc_line_filter u_filt (
		.clk(clk),
		.clk_en(clk_en),
		.rst_n(rst_n_s),
		.line_raw(line_state),
		.delay_log2(ctrl_q[utc_pkg::CTRL_DLY_LSB +: 4]),
		.line_filt(ls_filt),
		.changed(ls_chg)
	);

	// ****************************************
	// Suspend controller
	// ****************************************
	always_comb begin
		state_d = state_q;
		set_rst_flag = 1'b0;
		set_res_flag = 1'b0;
		unique case (state_q)
			utc_pkg::UTC_ACTIVE: begin
				if (suspend_req && !sreq_q) begin
					state_d = utc_pkg::UTC_SUSPEND;
				end
			end
			utc_pkg::UTC_SUSPEND: begin
				if (ctrl_q[utc_pkg::CTRL_HW_SUSP_BIT] && ls_filt == utc_pkg::LS_SE0) begin
					set_rst_flag = 1'b1;
					state_d = utc_pkg::UTC_RESUME;
				end else if (ctrl_q[utc_pkg::CTRL_HW_SUSP_BIT] && ls_filt == utc_pkg::LS_K) begin
					set_res_flag = 1'b1;
					state_d = utc_pkg::UTC_RESUME;
				end else if (!suspend_req) begin
					// Software-handled wakeup: unit drops its request
					state_d = utc_pkg::UTC_ACTIVE;
				end
			end
			utc_pkg::UTC_RESUME: begin
				if (ls_filt == utc_pkg::LS_J) begin
					state_d = utc_pkg::UTC_ACTIVE;
				end
			end
			default: begin
				state_d = utc_pkg::UTC_ACTIVE;
			end
		endcase
		susp_b_d = (state_d != utc_pkg::UTC_SUSPEND);
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			state_q <= utc_pkg::UTC_ACTIVE;
			susp_b_q <= 1'b1;
			sreq_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			susp_b_q <= susp_b_d;
			sreq_q <= suspend_req;
		end
	end

	// ****************************************
	// Register writes and interrupt status
	// ****************************************
	always_comb begin
		ep_mask_d = ep_mask_q;
		otg_mask_d = otg_mask_q;
		pwr_d = pwr_q;
		ctrl_d = ctrl_q;
		irq_mask_d = irq_mask_q;
		irq_clr = 4'h0;
		if (reg_wr) begin
			unique case (reg_addr)
				utc_pkg::OFS_ENDPOINT_MARK_MASK: ep_mask_d = reg_wdata[15:0];
				utc_pkg::OFS_OTG_FLAG_MASK: otg_mask_d = reg_wdata;
				utc_pkg::OFS_POWER_SIGNALLING: pwr_d = reg_wdata[8:0];
				utc_pkg::OFS_TRANSCEIVER_CONTROL: ctrl_d = reg_wdata & utc_pkg::CTRL_WMASK;
				utc_pkg::OFS_IRQ_STATUS: irq_clr = reg_wdata[3:0];
				utc_pkg::OFS_IRQ_MASK: irq_mask_d = reg_wdata[3:0];
				default: begin
				end
			endcase
		end
		// Hardware set wins over a software clear
		if (set_rst_flag) begin
			ctrl_d[utc_pkg::CTRL_RST_FLAG_BIT] = 1'b1;
		end
		if (set_res_flag) begin
			ctrl_d[utc_pkg::CTRL_RES_FLAG_BIT] = 1'b1;
		end
		irq_ev = 4'h0;
		irq_ev[utc_pkg::IRQ_TOKEN_BIT] = tok_valid;
		irq_ev[utc_pkg::IRQ_RESUME_BIT] = set_res_flag;
		irq_ev[utc_pkg::IRQ_RESET_BIT] = set_rst_flag;
		irq_ev[utc_pkg::IRQ_LINE_BIT] = ls_chg;
		irq_st_d = utc_pkg::utc_w1c(irq_st_q, irq_clr, irq_ev);
		irq_d = |(irq_st_d & irq_mask_d);
	end

	// ****************************************
	// Register reads
	// ****************************************
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				utc_pkg::OFS_LAST_PACKET_ID: rdata_d[3:0] = pid_v;
				utc_pkg::OFS_LAST_ENDPOINT: begin
					rdata_d[3:0] = ep_v;
					rdata_d[utc_pkg::EP_VALID_BIT] = ep_ok;
				end
				utc_pkg::OFS_ENDPOINT_MARK_MASK: rdata_d[15:0] = ep_mask_q;
				utc_pkg::OFS_OTG_FLAG_MASK: rdata_d = otg_mask_q;
				utc_pkg::OFS_POWER_SIGNALLING: rdata_d[8:0] = pwr_q;
				utc_pkg::OFS_TRANSCEIVER_CONTROL: rdata_d = ctrl_q;
				utc_pkg::OFS_LINE_STATUS: begin
					rdata_d[1:0] = ls_filt;
					rdata_d[utc_pkg::LSTAT_STATE_LSB +: 2] = state_q;
				end
				utc_pkg::OFS_IRQ_STATUS: rdata_d[3:0] = irq_st_q;
				utc_pkg::OFS_IRQ_MASK: rdata_d[3:0] = irq_mask_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			ep_mask_q <= utc_pkg::EP_MASK_RST;
			otg_mask_q <= utc_pkg::OTG_MASK_RST;
			pwr_q <= utc_pkg::PWR_RST;
			ctrl_q <= utc_pkg::CTRL_RST;
			irq_st_q <= utc_pkg::IRQ_RST;
			irq_mask_q <= utc_pkg::IRQ_RST;
			irq_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			ep_mask_q <= ep_mask_d;
			otg_mask_q <= otg_mask_d;
			pwr_q <= pwr_d;
			ctrl_q <= ctrl_d;
			irq_st_q <= irq_st_d;
			irq_mask_q <= irq_mask_d;
			irq_q <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata = rdata_q;
	assign phy_suspend_b = susp_b_q;
	assign transceiver_config_pins = ctrl_q[utc_pkg::CTRL_CFG_LSB +: 3];
	assign pulldown_off_8a = ctrl_q[utc_pkg::CTRL_PD_OFF_BIT];
	assign pulldown_off_8b = ctrl_q[utc_pkg::CTRL_PD_OFF_BIT];
	assign line_state_filt = ls_filt;
	assign irq = irq_q;

	// ****************************************
	// Assertions
	// ****************************************
	property p_pid_capture;
		@(posedge clk) disable iff (!rst_n_s)
		(clk_en && pkt_valid) |=> (pid_v == $past(pkt_pid));
	endproperty
	a_pid_capture: assert property (p_pid_capture) else $error("Packet identifier not captured");

	property p_ep_capture;
		@(posedge clk) disable iff (!rst_n_s)
		(clk_en && tok_valid) |=> (ep_v == $past(tok_ep));
	endproperty
	a_ep_capture: assert property (p_ep_capture) else $error("Endpoint not captured");

	property p_ep_valid;
		@(posedge clk) disable iff (!rst_n_s)
		(clk_en && (pkt_valid || tok_valid)) |=> (ep_ok == $past(tok_valid));
	endproperty
	a_ep_valid: assert property (p_ep_valid) else $error("Endpoint valid flag wrong");

	property p_mask_write;
		@(posedge clk) disable iff (!rst_n_s)
		(clk_en && reg_wr && reg_addr == utc_pkg::OFS_ENDPOINT_MARK_MASK)
		|=> (ep_mask_q == $past(reg_wdata[15:0]));
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("Endpoint mask not written");

	property p_rx_mark;
		@(posedge clk) disable iff (!rst_n_s)
		(clk_en && tok_valid && ep_mask_q[tok_ep])
		|=> (rx_valid && rx_data == (utc_pkg::RX_MARK | {4'h0, $past(tok_ep)}));
	endproperty
	a_rx_mark: assert property (p_rx_mark) else $error("Marked endpoint not on receive port");

	property p_pulldown;
		@(posedge clk) disable iff (!rst_n_s)
		(clk_en && reg_wr && reg_addr == utc_pkg::OFS_TRANSCEIVER_CONTROL)
		|=> (pulldown_off_8a == $past(reg_wdata[18]) && pulldown_off_8b == pulldown_off_8a);
	endproperty
	a_pulldown: assert property (p_pulldown) else $error("Pulldown control wrong");

	property p_reset_flag;
		@(posedge clk) disable iff (!rst_n_s)
		(clk_en && state_q == utc_pkg::UTC_SUSPEND && ctrl_q[7] && ls_filt == utc_pkg::LS_SE0)
		|=> (ctrl_q[13] && state_q == utc_pkg::UTC_RESUME && phy_suspend_b);
	endproperty
	a_reset_flag: assert property (p_reset_flag) else $error("Reset flag not set on SE0 resume");

	property p_resume_flag;
		@(posedge clk) disable iff (!rst_n_s)
		(clk_en && state_q == utc_pkg::UTC_SUSPEND && ctrl_q[7] && ls_filt == utc_pkg::LS_K)
		|=> (ctrl_q[12] && state_q == utc_pkg::UTC_RESUME && phy_suspend_b);
	endproperty
	a_resume_flag: assert property (p_resume_flag) else $error("Resume flag not set on K resume");

	property p_sw_resume;
		@(posedge clk) disable iff (!rst_n_s)
		(clk_en && state_q == utc_pkg::UTC_SUSPEND && !ctrl_q[7] && suspend_req)
		|=> (state_q == utc_pkg::UTC_SUSPEND && !phy_suspend_b);
	endproperty
	a_sw_resume: assert property (p_sw_resume) else $error("Hardware resumed while disabled");

	property p_config_pins;
		@(posedge clk) disable iff (!rst_n_s)
		(clk_en && reg_wr && reg_addr == utc_pkg::OFS_TRANSCEIVER_CONTROL)
		|=> (transceiver_config_pins == $past(reg_wdata[6:4]));
	endproperty
	a_config_pins: assert property (p_config_pins) else $error("Config pins not driven from field");

	property p_power_read;
		@(posedge clk) disable iff (!rst_n_s)
		(clk_en && reg_rd && reg_addr == utc_pkg::OFS_POWER_SIGNALLING)
		|=> (reg_rdata == {23'h00_0000, $past(pwr_q)});
	endproperty
	a_power_read: assert property (p_power_read) else $error("Power register read wrong");

endmodule

// ==== testbench/utc_phy_model.sv ====
// Purpose: Transceiver and bus stand-in that faces the block's line and pin outputs
// Assumes: Bench chooses the bus level; one clock domain
// Notes: Line level holds while suspended so software can still poll it

`timescale 1ns/1ps

module utc_phy_model (
	// Clock
	input wire logic clk,
	// Transceiver controls
	input wire logic phy_suspend_b,
	input wire logic [2:0] transceiver_config_pins,
	input wire logic pulldown_off_8a,
	input wire logic pulldown_off_8b,
	// Line
	output logic [1:0] line_state
);
	// ****************************************
	// Bus level
	// ****************************************
	logic [1:0] bus_level = utc_pkg::LS_J;
	logic [2:0] cfg_seen;
	logic susp_seen;

	// Level changes land on the edge the bench picks
	task automatic set_bus(input logic [1:0] v);
		bus_level <= v;
	endtask

	// Receiver keeps reporting the line in suspend
	assign line_state = bus_level;

	always_ff @(posedge clk) begin
		cfg_seen <= transceiver_config_pins;
		susp_seen <= ~phy_suspend_b;
	end
endmodule

// ==== testbench/test_utc_top.sv ====
// Purpose: Self-checking bench for the token capture and transceiver control block
// Assumes: Transceiver model drives the line; clk_en held high except in test_clk_en
// Notes: Filter delays are measured in edges from the bus change

`timescale 1ns/1ps

module test_utc_top;
	// ****************************************
	// Signals
	// ****************************************
	logic clk;
	logic clk_en;
	logic rst_b;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr, reg_rd;
	logic [31:0] reg_rdata;
	logic pkt_valid, tok_valid;
	logic [3:0] pkt_pid, tok_ep;
	logic rx_valid;
	logic [7:0] rx_data;
	logic [1:0] line_state, line_state_filt;
	logic suspend_req, phy_suspend_b, pulldown_off_8a, pulldown_off_8b, irq;
	logic [2:0] transceiver_config_pins;
	int error_cnt = 0;
	int check_count = 0;
	localparam logic [7:0] A_PID = utc_pkg::OFS_LAST_PACKET_ID;
	localparam logic [7:0] A_EP = utc_pkg::OFS_LAST_ENDPOINT;
	localparam logic [7:0] A_CTRL = utc_pkg::OFS_TRANSCEIVER_CONTROL;
	localparam logic [7:0] A_LS = utc_pkg::OFS_LINE_STATUS;
	localparam logic [7:0] A_IST = utc_pkg::OFS_IRQ_STATUS;
	localparam logic [7:0] A_IMK = utc_pkg::OFS_IRQ_MASK;

	utc_top utc_top_inst (.clk(clk), .clk_en(clk_en), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pkt_valid(pkt_valid), .pkt_pid(pkt_pid),
		.tok_valid(tok_valid), .tok_ep(tok_ep), .rx_valid(rx_valid), .rx_data(rx_data),
		.line_state(line_state), .suspend_req(suspend_req), .phy_suspend_b(phy_suspend_b),
		.transceiver_config_pins(transceiver_config_pins), .pulldown_off_8a(pulldown_off_8a),
		.pulldown_off_8b(pulldown_off_8b), .line_state_filt(line_state_filt), .irq(irq));

	utc_phy_model utc_phy_model_inst (.clk(clk), .phy_suspend_b(phy_suspend_b),
		.transceiver_config_pins(transceiver_config_pins), .pulldown_off_8a(pulldown_off_8a),
		.pulldown_off_8b(pulldown_off_8b), .line_state(line_state));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ****************************************
	// Checks and bus cycles
	// ****************************************
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_cnt(input string name, input int lo, input int hi, input int got);
		check_count++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(name, exp, reg_rdata);
	endtask

	task automatic wait_filt(input logic [1:0] v, input int lim, output int cnt);
		cnt = 0;
		while (line_state_filt !== v) begin
			@(posedge clk);
			#1;
			cnt++;
			if (cnt > lim) begin
				error_cnt++;
				$display("[ERR] line_state_filt expected %b seen %b", v, line_state_filt);
				test_done();
			end
		end
	endtask

	task automatic wait_susp(input logic v, input int lim);
		for (int i = 0; i < lim; i++) begin
			@(posedge clk);
			#1;
			if (phy_suspend_b === v) return;
		end
		error_cnt++;
		$display("[ERR] phy_suspend_b expected %b seen %b", v, phy_suspend_b);
		test_done();
	endtask

	task automatic bus_to(input logic [1:0] v);
		int cnt;
		@(posedge clk);
		utc_phy_model_inst.set_bus(v);
		wait_filt(v, 60, cnt);
	endtask

	task automatic send_pkt(input logic [3:0] pid, input logic tok, input logic [3:0] ep, input logic [7:0] exp);
		@(posedge clk);
		pkt_valid <= 1'b1;
		pkt_pid <= pid;
		tok_valid <= tok;
		tok_ep <= ep;
		@(posedge clk);
		pkt_valid <= 1'b0;
		tok_valid <= 1'b0;
		#1;
		chk("rx_valid", {31'h0, tok}, {31'h0, rx_valid});
		chk("rx_data", {24'h0, exp}, {24'h0, rx_data});
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_regs();
		for (logic [7:0] a = 8'h2c; a <= 8'h40; a += 8'h04) rd("reset value", a, 32'h0000_0000);
		rd("irq mask reset", A_IMK, 32'h0000_0000);
		chk("suspend idle", 32'h0000_0001, {31'h0, phy_suspend_b});
		wr(8'h50, 32'hffff_ffff);
		rd("unmapped", 8'h50, 32'h0000_0000);
		wr(utc_pkg::OFS_OTG_FLAG_MASK, 32'ha5a5_5a5a);
		rd("otg mask", utc_pkg::OFS_OTG_FLAG_MASK, 32'ha5a5_5a5a);
		wr(utc_pkg::OFS_POWER_SIGNALLING, 32'hffff_ffff);
		rd("power", utc_pkg::OFS_POWER_SIGNALLING, 32'h0000_01ff);
		wr(A_CTRL, 32'hffff_ffff);
		rd("control", A_CTRL, 32'h0004_3ff0);
		chk("config pins", 32'h0000_0007, {29'h0, transceiver_config_pins});
		chk("pulldowns off", 32'h0000_0003, {30'h0, pulldown_off_8a, pulldown_off_8b});
		wr(A_CTRL, 32'h0000_0050);
		rd("flags cleared", A_CTRL, 32'h0000_0050);
		chk("config pins", 32'h0000_0005, {29'h0, transceiver_config_pins});
		chk("pulldowns on", 32'h0000_0000, {30'h0, pulldown_off_8a, pulldown_off_8b});
	endtask

	task automatic test_tokens();
		wr(utc_pkg::OFS_ENDPOINT_MARK_MASK, 32'hffff_8008);
		rd("ep mask", utc_pkg::OFS_ENDPOINT_MARK_MASK, 32'h0000_8008);
		send_pkt(4'h9, 1'b1, 4'h3, 8'h13);
		rd("pid", A_PID, 32'h0000_0009);
		rd("endpoint", A_EP, 32'h0000_0013);
		send_pkt(4'hf, 1'b1, 4'hf, 8'h1f);
		send_pkt(4'h5, 1'b1, 4'h5, 8'h05);
		send_pkt(4'h2, 1'b0, 4'h0, 8'h00);
		wr(A_PID, 32'hffff_ffff);
		rd("pid", A_PID, 32'h0000_0002);
		rd("endpoint", A_EP, 32'h0000_0005);
	endtask

	task automatic test_filter(input logic [3:0] n, input logic [1:0] v);
		int cnt;
		wr(A_CTRL, 32'(n) << utc_pkg::CTRL_DLY_LSB);
		@(posedge clk);
		utc_phy_model_inst.set_bus(v);
		wait_filt(v, 2 ** n + 20, cnt);
		chk_cnt("filter delay", 2 ** n + 3, 2 ** n + 5, cnt);
		rd("line status", A_LS, {30'h0, v});
	endtask

	task automatic test_hw_resume();
		wr(A_CTRL, 32'h0000_0080);
		wr(A_IMK, 32'h0000_0002);
		wr(A_IST, 32'h0000_000f);
		chk("irq idle", 32'h0000_0000, {31'h0, irq});
		suspend_req <= 1'b1;
		wait_susp(1'b0, 5);
		bus_to(utc_pkg::LS_K);
		wait_susp(1'b1, 20);
		rd("resume flag", A_CTRL, 32'h0000_1080);
		chk("irq resume", 32'h0000_0001, {31'h0, irq});
		wr(A_CTRL, 32'h0000_1080);
		rd("flag kept", A_CTRL, 32'h0000_1080);
		wr(A_CTRL, 32'h0000_0080);
		rd("flag cleared", A_CTRL, 32'h0000_0080);
		suspend_req <= 1'b0;
		bus_to(utc_pkg::LS_J);
		rd("back active", A_LS, 32'h0000_0001);
		wr(A_IST, 32'h0000_000f);
		suspend_req <= 1'b1;
		wait_susp(1'b0, 5);
		bus_to(utc_pkg::LS_SE0);
		wait_susp(1'b1, 20);
		rd("reset flag", A_CTRL, 32'h0000_2080);
		rd("irq status", A_IST, 32'h0000_000c);
		chk("irq masked", 32'h0000_0000, {31'h0, irq});
		wr(A_IMK, 32'h0000_0004);
		chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
		wr(A_IST, 32'h0000_000f);
		chk("irq cleared", 32'h0000_0000, {31'h0, irq});
		suspend_req <= 1'b0;
		bus_to(utc_pkg::LS_J);
		wr(A_CTRL, 32'h0000_0000);
		rd("flags cleared", A_CTRL, 32'h0000_0000);
	endtask

	task automatic test_sw_resume();
		suspend_req <= 1'b1;
		wait_susp(1'b0, 5);
		bus_to(utc_pkg::LS_K);
		repeat (10) @(posedge clk);
		#1;
		chk("still suspended", 32'h0000_0000, {31'h0, phy_suspend_b});
		rd("no flags", A_CTRL, 32'h0000_0000);
		rd("polled line", A_LS, 32'h0000_0006);
		suspend_req <= 1'b0;
		wait_susp(1'b1, 5);
		bus_to(utc_pkg::LS_J);
	endtask

	// Write while the enable is low must not land
	task automatic test_clk_en();
		@(posedge clk);
		clk_en <= 1'b0;
		wr(A_CTRL, 32'h0000_0070);
		chk("frozen pins", 32'h0000_0000, {29'h0, transceiver_config_pins});
		@(posedge clk);
		clk_en <= 1'b1;
		rd("frozen control", A_CTRL, 32'h0000_0000);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		pkt_valid = 1'b0;
		pkt_pid = 4'h0;
		tok_valid = 1'b0;
		tok_ep = 4'h0;
		suspend_req = 1'b0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		test_regs();
		test_tokens();
		test_filter(4'h0, utc_pkg::LS_K);
		test_filter(4'h3, utc_pkg::LS_J);
		test_hw_resume();
		test_sw_resume();
		test_clk_en();
		test_done();
	end
endmodule
